// *** hdl/fail_safe_clock_monitor_monitor.sv ***
// Fail-safe clock monitor with start-up hold-off and clock selection.
//
// Contract
// - Monitor and watchdog share the internal RC source.
// - On failure, device runs from internal mux clock.
// - Every fail-safe event clears watchdog and postscaler; the code only pulses watchdog_clear_o and has no postscaler.
// - Fail-safe ends only on reset, wake or power-managed entry.
// - After reset, internal clock until primary ready, flag set.
// - After switch to primary, monitoring resumes.
// - Primary never ready: stay internal, control reg unchanged.
// - Power-managed entry selects control register source, monitored only when that source is the primary.
// - Failure in power-managed mode never switches back automatically.
// - Idle failure with interrupt enabled wakes on internal clock; without it, CPU stays idle.
// - Non-crystal modes monitor immediately after wake; after reset, only once primary ready.
// - Crystal modes hold off monitoring until timers expire.
// - Crystal that never starts raises no failure flag.
// - New power-managed mode not using primary disables primary, also during start-up.
// - Sample clock is internal RC divided by 64.
// - Latch set by device clock fall, cleared by sample rise.
// - Failure when sample falling edge finds latch set.
// - Failure sets fail flag; control register not updated.
`timescale 1ns/100ps

module fscmon_core #(
  parameter int unsigned SAMPLE_DIV = fscmon_pkg::SAMPLE_DIV
) (
  // Clock and reset
  input  wire logic                                 clk_sys_i,
  input  wire logic                                 rst_n_i,
  // Internal RC source tick and monitored clock
  input  wire logic                                 rc_tick_i,
  input  wire logic                                 dev_clk_i,
  // Configuration
  input  wire logic                                 monitor_en_i,
  input  wire fscmon_pkg::fscmon_mode_t             primary_mode_i,
  input  wire logic [fscmon_pkg::FREQ_SEL_W-1:0]    internal_freq_select_i,
  // Start-up and power management
  input  wire logic                                 wake_i,
  input  wire logic                                 primary_ready_i,
  input  wire logic                                 pm_enter_i,
  input  wire logic                                 pm_idle_i,
  input  wire logic                                 pm_use_primary_i,
  input  wire logic [fscmon_pkg::OSC_CTRL_W-1:0]    osc_ctrl_wdata_i,
  input  wire logic                                 wake_irq_i,
  // Software side
  input  wire logic                                 fail_flag_clr_i,
  input  wire logic                                 fail_int_en_i,
  input  wire logic                                 watchdog_en_i,
  // Outputs
  output logic                                      rc_source_on_o,
  output logic                                      sel_internal_o,
  output logic [fscmon_pkg::FREQ_SEL_W-1:0]         internal_freq_o,
  output logic                                      primary_enable_o,
  output logic                                      primary_clock_running_flag_o,
  output logic [fscmon_pkg::OSC_CTRL_W-1:0]         oscillator_control_reg_o,
  output logic                                      osc_fail_int_flag_o,
  output logic                                      watchdog_clear_o,
  output logic                                      cpu_run_o
);

  if (SAMPLE_DIV < 2 || (SAMPLE_DIV % 2) != 0) begin : g_div_check
    $error("SAMPLE_DIV must be even and at least 2.");
  end

  localparam int unsigned DW = $clog2(SAMPLE_DIV);

  // ****************************************
  // Sample clock and monitor latch
  // ****************************************
  logic [DW-1:0] div_q, div_d;
  logic          samp_q, samp_d;
  logic          latch_q, latch_d;
  logic          dclk_q, dclk_d;
  logic          fail_det;
  logic          monitoring;

  always_comb begin
    div_d    = div_q;
    samp_d   = samp_q;
    dclk_d   = dev_clk_i;
    latch_d  = latch_q;
    fail_det = 1'b0;
    if (rc_tick_i) begin
      if (div_q == DW'(SAMPLE_DIV/2 - 1)) begin
        div_d  = '0;
        samp_d = ~samp_q;
      end else begin
        div_d = div_q + DW'(1);
      end
    end
    if (dclk_q && !dev_clk_i) begin
      latch_d = 1'b1;
    end
    if (rc_tick_i && samp_d && !samp_q) begin
      latch_d = 1'b0;
    end
    if (rc_tick_i && !samp_d && samp_q && latch_q && monitoring) begin
      fail_det = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q   <= '0;
      samp_q  <= 1'b0;
      latch_q <= 1'b0;
      dclk_q  <= 1'b0;
    end else begin
      div_q   <= div_d;
      samp_q  <= samp_d;
      latch_q <= latch_d;
      dclk_q  <= dclk_d;
    end
  end

  // ****************************************
  // Clock source control
  // ****************************************
  fscmon_pkg::fscmon_state_t         st_q, st_d;
  logic                              flag_q, flag_d;
  logic                              run_q, run_d;
  logic                              cpu_q, cpu_d;
  logic                              pm_prim_q, pm_prim_d;
  logic [fscmon_pkg::OSC_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic                              wdclr_d, wdclr_q;
  logic [fscmon_pkg::FREQ_SEL_W-1:0] freq_q;
  logic                              crystal;

  always_comb begin
    crystal = (primary_mode_i == fscmon_pkg::FSCMON_MODE_SLOW_XTAL)
           || (primary_mode_i == fscmon_pkg::FSCMON_MODE_STD_XTAL)
           || (primary_mode_i == fscmon_pkg::FSCMON_MODE_FAST_XTAL)
           || (primary_mode_i == fscmon_pkg::FSCMON_MODE_FAST_PLL);
    monitoring = monitor_en_i && (st_q == fscmon_pkg::FSCMON_ST_PRIMARY
               || (st_q == fscmon_pkg::FSCMON_ST_PM && pm_prim_q));
  end

  always_comb begin
    st_d      = st_q;
    flag_d    = flag_q;
    run_d     = run_q;
    cpu_d     = cpu_q;
    pm_prim_d = pm_prim_q;
    ctrl_d    = ctrl_q;
    wdclr_d   = (internal_freq_select_i != freq_q);
    if (wake_i) begin
      st_d  = crystal ? fscmon_pkg::FSCMON_ST_STARTUP
                      : fscmon_pkg::FSCMON_ST_PRIMARY;
      run_d = !crystal;
    end else if (pm_enter_i) begin
      st_d      = fscmon_pkg::FSCMON_ST_PM;
      pm_prim_d = pm_use_primary_i;
      ctrl_d    = osc_ctrl_wdata_i;
      run_d     = pm_use_primary_i;
      cpu_d     = !pm_idle_i;
    end else begin
      unique case (st_q)
        fscmon_pkg::FSCMON_ST_STARTUP: begin
          if (primary_ready_i) begin
            st_d  = fscmon_pkg::FSCMON_ST_PRIMARY;
            run_d = 1'b1;
          end
        end
        fscmon_pkg::FSCMON_ST_PRIMARY: begin
          if (fail_det) begin
            st_d  = fscmon_pkg::FSCMON_ST_FAILSAFE;
            run_d = 1'b0;
          end
        end
        fscmon_pkg::FSCMON_ST_FAILSAFE: begin
          st_d = fscmon_pkg::FSCMON_ST_FAILSAFE;
        end
        fscmon_pkg::FSCMON_ST_PM: begin
          if (fail_det) begin
            st_d  = fscmon_pkg::FSCMON_ST_FAILSAFE;
            run_d = 1'b0;
            if (fail_int_en_i) begin
              cpu_d = 1'b1;
            end
          end
        end
      endcase
    end
    if (!cpu_q && wake_irq_i) begin
      cpu_d = 1'b1;
    end
    if (fail_flag_clr_i) begin
      flag_d = 1'b0;
    end
    if (fail_det) begin
      flag_d  = 1'b1;
      wdclr_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q      <= fscmon_pkg::FSCMON_ST_STARTUP;
      flag_q    <= 1'b0;
      run_q     <= 1'b0;
      cpu_q     <= 1'b1;
      pm_prim_q <= 1'b0;
      ctrl_q    <= fscmon_pkg::OSC_CTRL_RESET;
      wdclr_q   <= 1'b0;
      freq_q    <= '0;
    end else begin
      st_q      <= st_d;
      flag_q    <= flag_d;
      run_q     <= run_d;
      cpu_q     <= cpu_d;
      pm_prim_q <= pm_prim_d;
      ctrl_q    <= ctrl_d;
      wdclr_q   <= wdclr_d;
      freq_q    <= internal_freq_select_i;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rc_source_on_o               = monitor_en_i || watchdog_en_i;
  assign sel_internal_o               = !run_q;
  assign internal_freq_o              = freq_q;
  assign primary_enable_o             = (st_q != fscmon_pkg::FSCMON_ST_PM) || pm_prim_q;
  assign primary_clock_running_flag_o = run_q;
  assign oscillator_control_reg_o     = ctrl_q;
  assign osc_fail_int_flag_o          = flag_q;
  assign watchdog_clear_o             = wdclr_q;
  assign cpu_run_o                    = cpu_q;

endmodule

// *** hdl/fail_safe_clock_monitor_pkg.sv ***
// Package of constants and types for the fail-safe clock monitor.
package fscmon_pkg;

  // ****************************************
  // Sample clock and sizes
  // ****************************************
  localparam int unsigned SAMPLE_DIV     = 64;
  localparam int unsigned FREQ_SEL_W     = 3;
  localparam int unsigned OSC_CTRL_W     = 8;
  localparam logic [7:0]  OSC_CTRL_RESET = 8'h00;

  // ****************************************
  // Primary oscillator modes
  // ****************************************
  typedef enum logic [2:0] {
    FSCMON_MODE_EXT_CLOCK,
    FSCMON_MODE_EXT_RC,
    FSCMON_MODE_INT_RC,
    FSCMON_MODE_SLOW_XTAL,
    FSCMON_MODE_STD_XTAL,
    FSCMON_MODE_FAST_XTAL,
    FSCMON_MODE_FAST_PLL
  } fscmon_mode_t;

  // ****************************************
  // Clock control states
  // ****************************************
  typedef enum logic [1:0] {
    FSCMON_ST_STARTUP,
    FSCMON_ST_PRIMARY,
    FSCMON_ST_FAILSAFE,
    FSCMON_ST_PM
  } fscmon_state_t;

endpackage

// *** verif/fail_safe_clock_monitor_props.sv ***
// Checker of the fail-safe clock monitor port behaviour.
`timescale 1ns/100ps
module fscmon_props (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       monitor_en_i,
  input wire logic [2:0] internal_freq_select_i,
  input wire logic       wake_i,
  input wire logic       pm_enter_i,
  input wire logic       pm_use_primary_i,
  input wire logic [7:0] osc_ctrl_wdata_i,
  input wire logic       fail_flag_clr_i,
  input wire logic       rc_source_on_o,
  input wire logic       sel_internal_o,
  input wire logic       primary_enable_o,
  input wire logic       primary_clock_running_flag_o,
  input wire logic [7:0] oscillator_control_reg_o,
  input wire logic       osc_fail_int_flag_o,
  input wire logic       watchdog_clear_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_rc_src_on: assert property (monitor_en_i |-> rc_source_on_o)
    else $error("rc source off while monitor enabled");
  a_fail_sel_int: assert property ($rose(osc_fail_int_flag_o) |-> sel_internal_o)
    else $error("failure without internal clock");
  a_fail_wd_clr: assert property ($rose(osc_fail_int_flag_o) |-> watchdog_clear_o)
    else $error("failure without watchdog clear");
  a_freq_wd_clr: assert property ($changed(internal_freq_select_i) |=> watchdog_clear_o)
    else $error("frequency change without watchdog clear");
  a_fail_hold: assert property ($rose(osc_fail_int_flag_o) ##1 (!pm_enter_i && !wake_i) [*3]
    |=> sel_internal_o)
    else $error("fail-safe left without exit event");
  a_ctrl_keep: assert property (!pm_enter_i |=> $stable(oscillator_control_reg_o))
    else $error("control register changed without mode entry");
  a_pm_primary: assert property (pm_enter_i && pm_use_primary_i && !wake_i |=> !sel_internal_o
    && oscillator_control_reg_o == $past(osc_ctrl_wdata_i))
    else $error("mode entry did not select primary");
  a_start_no_fail: assert property (sel_internal_o && !osc_fail_int_flag_o
    |=> !osc_fail_int_flag_o)
    else $error("failure raised on internal clock");
  a_pm_pri_off: assert property (pm_enter_i && !pm_use_primary_i && !wake_i
    |=> !primary_enable_o)
    else $error("primary kept on after mode entry");
  a_ready_switch: assert property ($rose(primary_clock_running_flag_o) |-> !sel_internal_o)
    else $error("running flag without primary clock");
  a_flag_sticky: assert property (osc_fail_int_flag_o && !fail_flag_clr_i
    |=> osc_fail_int_flag_o)
    else $error("fail flag dropped without clear");
endmodule

// *** verif/fail_safe_clock_monitor_osc_model.sv ***
// Behavioural model of the external primary oscillator.
`timescale 1ns/100ps
module fscmon_osc_model #(parameter int START_CYC = 40) (
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic start_ok_i,
  input  wire logic fault_i,
  output logic      dev_clk_o,
  output logic      ready_o
);
  int cnt = 0;
  initial begin
    dev_clk_o = 1'b1;
    ready_o = 1'b0;
  end
  always @(posedge clk_i) begin
    // Start-up timer runs only while powered and able to start.
    cnt <= (en_i && start_ok_i) ? cnt + 1 : 0;
    ready_o <= en_i && start_ok_i && cnt >= START_CYC;
    // A faulty source gives falling edges the sample clock cannot clear in time.
    dev_clk_o <= (en_i && fault_i) ? !dev_clk_o : 1'b1;
  end
endmodule

// *** verif/tb.sv ***
// Self-checking bench of the fail-safe clock monitor.
`timescale 1ns/100ps
module tb;
  logic       clk_sys_i = 0, rst_n_i = 0, wake = 0, pme = 0, idle = 0, usep = 0, clr = 0;
  logic       ien = 1, wirq = 0, sok = 0, flt = 0, dclk, rdy, tick;
  logic       mon_en = 1, wd_en = 0;
  logic       sel, pen, runf, fail, cpu, rcon, wdc;
  logic [1:0] tc = 2'h0;
  logic [2:0] fsel = 3'h0, fq;
  logic [7:0] wd = 8'h00, ctrl;
  // Row bits: source on, watchdog enable, monitor enable, internal select, mode.
  logic [6:0] rows [7] = '{7'h50, 7'h61, 7'h02, 7'h7B, 7'h5C, 7'h5D, 7'h5E};
  fscmon_pkg::fscmon_mode_t mode = fscmon_pkg::FSCMON_MODE_FAST_XTAL;
  int         mismatches = 0, cmp_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) tc <= tc + 2'h1;
  assign tick = (tc == 2'h0);
  fscmon_osc_model i_osc (.clk_i(clk_sys_i), .en_i(pen), .start_ok_i(sok), .fault_i(flt),
    .dev_clk_o(dclk), .ready_o(rdy));
  fscmon_core #(.SAMPLE_DIV(4)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .rc_tick_i(tick), .dev_clk_i(dclk), .monitor_en_i(mon_en), .primary_mode_i(mode),
    .internal_freq_select_i(fsel), .wake_i(wake), .primary_ready_i(rdy), .pm_enter_i(pme),
    .pm_idle_i(idle), .pm_use_primary_i(usep), .osc_ctrl_wdata_i(wd), .wake_irq_i(wirq),
    .fail_flag_clr_i(clr), .fail_int_en_i(ien), .watchdog_en_i(wd_en), .rc_source_on_o(rcon),
    .sel_internal_o(sel), .internal_freq_o(fq), .primary_enable_o(pen),
    .primary_clock_running_flag_o(runf), .oscillator_control_reg_o(ctrl),
    .osc_fail_int_flag_o(fail), .watchdog_clear_o(wdc), .cpu_run_o(cpu));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_for(ref logic s);
    for (int i = 0; i < 300 && s !== 1'b1; i++) cyc(1);
    if (s !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(4);
    rst_n_i = 1;
    chk("sel", 1, sel);
    chk("pen", 1, pen);
    chk("rcon", 1, rcon);
    foreach (rows[r]) begin
      mode   = fscmon_pkg::fscmon_mode_t'(rows[r][2:0]);
      mon_en = rows[r][4];
      wd_en  = rows[r][5];
      pulse(wake);
      cyc(2);
      chk("mode_sel", {7'h00, rows[r][3]}, sel);
      chk("rc_on", {7'h00, rows[r][6]}, rcon);
    end
    pulse(wake);
    sok = 1;
    wait_for(runf);
    chk("sel_pri", 0, sel);
    flt = 1;
    wait_for(fail);
    chk("wd_fail", 1, wdc);
    chk("sel_fail", 1, sel);
    chk("ctrl_fail", 8'h00, ctrl);
    flt = 0;
    cyc(20);
    chk("sel_hold", 1, sel);
    pulse(clr);
    chk("flag_clr", 0, fail);
    fsel = 3'h5;
    cyc(1);
    chk("wd_freq", 1, wdc);
    chk("freq", 3'h5, fq);
    cyc(1);
    chk("wd_once", 0, wdc);
    wd = 8'h5A;
    usep = 1;
    idle = 1;
    pulse(pme);
    chk("ctrl_pm", 8'h5A, ctrl);
    chk("sel_pm", 0, sel);
    chk("cpu_pm", 0, cpu);
    flt = 1;
    wait_for(fail);
    cyc(20);
    chk("sel_pmf", 1, sel);
    chk("cpu_pmf", 1, cpu);
    flt = 0;
    pulse(clr);
    ien = 0;
    idle = 1;
    pulse(pme);
    flt = 1;
    wait_for(fail);
    cyc(1);
    chk("cpu_idle", 0, cpu);
    flt = 0;
    pulse(wirq);
    chk("cpu_wake", 1, cpu);
    chk("sel_wake", 1, sel);
    rst_n_i = 0;
    sok = 0;
    cyc(4);
    rst_n_i = 1;
    chk("flag_rst", 0, fail);
    cyc(150);
    chk("flag_dead", 0, fail);
    chk("sel_dead", 1, sel);
    chk("ctrl_dead", 8'h00, ctrl);
    usep = 0;
    idle = 0;
    pulse(pme);
    chk("pen_off", 0, pen);
    conclude();
  end
endmodule
bind fscmon_core fscmon_props i_props (.*);
